// ==== design/lgp_pkg.sv ====
// Purpose: Shared constants for the LCD-shared GPIO ports D and E
// Assumes: Classic Wishbone, 32-bit data, one aligned word per register
// Notes:   Offsets are byte addresses
package lgp_pkg;

   // ************************************************************
   // Register map
   // ************************************************************
   localparam logic [7:0] OFS_PORT_D_PIN_DATA    = 8'h00;
   localparam logic [7:0] OFS_PORT_D_LATCH       = 8'h04;
   localparam logic [7:0] OFS_PORT_D_DIRECTION   = 8'h08;
   localparam logic [7:0] OFS_LCD_SEG_EN_0_7     = 8'h0c;
   localparam logic [7:0] OFS_PORT_E_PIN_DATA    = 8'h10;
   localparam logic [7:0] OFS_PORT_E_LATCH       = 8'h14;
   localparam logic [7:0] OFS_PORT_E_DIRECTION   = 8'h18;
   localparam logic [7:0] OFS_LCD_CONTROL        = 8'h1c;
   localparam logic [7:0] OFS_LCD_SEG_EN_24_31   = 8'h20;

   // ************************************************************
   // Fields and reset values
   // ************************************************************
   localparam int         PORT_D_WIDTH      = 8;
   localparam int         PORT_E_LSB        = 4;
   localparam int         LCD_MUX_LSB       = 0;
   localparam int         LCD_SEGMENT_THIRTY_ONE_BIT         = 7;
   localparam logic [7:0] PORT_E_IMPL_MASK  = 8'hf0;
   localparam logic [7:0] RST_DIRECTION     = 8'hff;
   localparam logic [7:0] RST_LATCH         = 8'h00;
   localparam logic [7:0] RST_LCD           = 8'h00;
   localparam int         SYNC_STAGES       = 2;

endpackage : lgp_pkg

// ==== design/lgp_sync.sv ====
// Purpose: Two-flop synchroniser for the pad input levels
// Assumes: Pad levels are asynchronous to clk_i
// Notes:   First stage feeds only the second stage
`timescale 1ns/10ps
`default_nettype none
module lgp_sync
   import lgp_pkg::*;
#(
   parameter int W = 8
) (
   // Clock and reset
   input  wire logic         clk_i,
   input  wire logic         rst_n_i,
   // Data
   input  wire logic [W-1:0] async_i,
   output logic      [W-1:0] sync_o
);
   logic [W-1:0] meta;

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         meta   <= '0;
         sync_o <= '0;
      end else begin
         meta   <= async_i;
         sync_o <= meta;
      end
   end
endmodule : lgp_sync
`default_nettype wire

// ==== design/lgp_pad_mux.sv ====
// Purpose: Per-pin output ownership for ports D and E
// Assumes: All inputs come from the same clock domain
// Notes:   Pure combinational; the top registers the results
`timescale 1ns/10ps
`default_nettype none
module lgp_pad_mux
   import lgp_pkg::*;
(
   // Port D controls
   input  wire logic [7:0] d_latch_i,
   input  wire logic [7:0] d_dir_i,
   input  wire logic [7:0] seg_en_lo_i,
   // Port E controls
   input  wire logic [7:0] e_latch_i,
   input  wire logic [7:0] e_dir_i,
   input  wire logic [1:0] lcd_mux_i,
   input  wire logic       lcd_segment_thirty_one_en_i,
   input  wire logic       ccp_alt_sel_i,
   input  wire logic       ccp_out_en_i,
   input  wire logic       ccp_out_i,
   // Results
   output logic      [7:0] d_out_o,
   output logic      [7:0] d_oe_o,
   output logic      [7:0] d_lcd_o,
   output logic      [7:0] e_out_o,
   output logic      [7:0] e_oe_o,
   output logic      [7:0] e_lcd_o
);
   // Pins of port E taken by LCD commons for a multiplex code
   function automatic logic [7:0] com_claim(input logic [1:0] mux);
      unique case (mux)
         2'b00:   com_claim = 8'h0f;
         2'b01:   com_claim = 8'h1f;
         2'b10:   com_claim = 8'h3f;
         default: com_claim = 8'h7f;
      endcase
   endfunction : com_claim

   always_comb begin
      d_lcd_o = seg_en_lo_i;
      d_oe_o  = ~d_dir_i & ~seg_en_lo_i;
      d_out_o = d_latch_i & d_oe_o;
      e_lcd_o = com_claim(lcd_mux_i);
      e_lcd_o[LCD_SEGMENT_THIRTY_ONE_BIT] = lcd_segment_thirty_one_en_i;
      e_oe_o  = ~e_dir_i & ~e_lcd_o & PORT_E_IMPL_MASK;
      e_out_o = e_latch_i & e_oe_o;
      // Compare unit owns pin 7 ahead of the latch when routed there, segment 31 is off, pin 7 direction is zero and its output enable is set
      if (!ccp_alt_sel_i && !lcd_segment_thirty_one_en_i && !e_dir_i[7]) begin
         e_out_o[7] = ccp_out_en_i ? ccp_out_i : e_latch_i[7];
      end
   end
endmodule : lgp_pad_mux
`default_nettype wire

// ==== design/lgp_top.sv ====
// Purpose: Ports D and E with LCD sharing, reached over classic Wishbone
// Assumes: 25 MHz clk_i, synchronous active-low reset, 32-bit Wishbone
// Notes:   Pads are split into in/out/oe; no tristate inside
//
// The implementer's own choices: register access over Wishbone and the register addresses.
`timescale 1ns/10ps
`default_nettype none
// Contract
// - Port D has eight pins, each with direction and latch bit.
// - Direction one makes the pin an input with driver off.
// - Direction zero drives the latch value onto the pin.
// - Latch register reads back the stored value, not pins.
// - Each pin's direction is independent.
// - Reset makes every pin of both ports an input.
// - Segment enable bit hands a port D pin to the LCD.
// - Direction bit is ignored while a pin serves the LCD.
// - Port E has four pins at bits 7 to 4, same behaviour.
// - Multiplex select chooses which port E pins 6..4 are commons.
// - Free pins: 00 gives 6,5,4; 01 gives 6,5; 10 gives 6; 11 none.
// - Segment 31 enable takes port E pin 7 for the LCD.
// - Port E bits 3..0 have no digital I/O.
// - Config bit zero routes compare unit two to port E pin 7.
// - Compare output wins over latch data on that pin.
// - Port E low four bits read as zero.
module lgp_top
   import lgp_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   // Wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // Port D pads
   input  wire logic [7:0]  port_d_pad_i,
   output logic      [7:0]  port_d_pad_o,
   output logic      [7:0]  port_d_pad_oe_o,
   output logic      [7:0]  port_d_lcd_seg_o,
   // Port E pads, bits 7..4 used
   input  wire logic [7:0]  port_e_pad_i,
   output logic      [7:0]  port_e_pad_o,
   output logic      [7:0]  port_e_pad_oe_o,
   output logic      [7:0]  port_e_lcd_o,
   // Compare unit two
   input  wire logic        compare_pin_select_cfg_i,
   input  wire logic        capture_compare_unit_two_out_en_i,
   input  wire logic        capture_compare_unit_two_out_i,
   output logic             capture_compare_unit_two_capture_o
);
   import lgp_pkg::*;

   // ************************************************************
   // Registers
   // ************************************************************
   logic [7:0] port_d_output_latch;
   logic [7:0] port_d_direction;
   logic [7:0] lcd_segment_enable_0_7;
   logic [7:0] port_e_output_latch;
   logic [7:0] port_e_direction;
   logic [7:0] lcd_control_reg;
   logic [7:0] lcd_segment_enable_24_31;
   logic [7:0] d_sync;
   logic [7:0] e_sync;
   logic [7:0] d_out;
   logic [7:0] d_oe;
   logic [7:0] d_lcd;
   logic [7:0] e_out;
   logic [7:0] e_oe;
   logic [7:0] e_lcd;
   logic [7:0] next_rdata;
   logic       req;
   logic       wr_lo;

   assign req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr_lo = req & wb_we_i & wb_sel_i[0];

   // ************************************************************
   // Pad input synchronisers
   // ************************************************************
   lgp_sync #(.W(8)) u_sync_d (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .async_i (port_d_pad_i),
      .sync_o  (d_sync)
   );

   lgp_sync #(.W(8)) u_sync_e (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .async_i (port_e_pad_i),
      .sync_o  (e_sync)
   );

   // ************************************************************
   // Register writes
   // ************************************************************
   // Latch, reachable through both data and latch offsets
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         port_d_output_latch <= RST_LATCH;
         port_e_output_latch <= RST_LATCH;
      end else if (wr_lo) begin
         if (wb_adr_i == OFS_PORT_D_PIN_DATA || wb_adr_i == OFS_PORT_D_LATCH) begin
            port_d_output_latch <= wb_dat_i[7:0];
         end
         if (wb_adr_i == OFS_PORT_E_PIN_DATA || wb_adr_i == OFS_PORT_E_LATCH) begin
            port_e_output_latch <= wb_dat_i[7:0] & PORT_E_IMPL_MASK;
         end
      end
   end

   // Direction registers come up ones on every implemented bit so every pin is an input
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         port_d_direction <= RST_DIRECTION;
         port_e_direction <= RST_DIRECTION & PORT_E_IMPL_MASK;
      end else if (wr_lo) begin
         if (wb_adr_i == OFS_PORT_D_DIRECTION) begin
            port_d_direction <= wb_dat_i[7:0];
         end
         if (wb_adr_i == OFS_PORT_E_DIRECTION) begin
            port_e_direction <= wb_dat_i[7:0] & PORT_E_IMPL_MASK;
         end
      end
   end

   // LCD sharing controls
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         lcd_segment_enable_0_7   <= RST_LCD;
         lcd_control_reg          <= RST_LCD;
         lcd_segment_enable_24_31 <= RST_LCD;
      end else if (wr_lo) begin
         if (wb_adr_i == OFS_LCD_SEG_EN_0_7) begin
            lcd_segment_enable_0_7 <= wb_dat_i[7:0];
         end
         if (wb_adr_i == OFS_LCD_CONTROL) begin
            lcd_control_reg <= wb_dat_i[7:0];
         end
         if (wb_adr_i == OFS_LCD_SEG_EN_24_31) begin
            lcd_segment_enable_24_31 <= wb_dat_i[7:0];
         end
      end
   end

   // ************************************************************
   // Pin ownership
   // ************************************************************
   lgp_pad_mux u_mux (
      .d_latch_i     (port_d_output_latch),
      .d_dir_i       (port_d_direction),
      .seg_en_lo_i   (lcd_segment_enable_0_7),
      .e_latch_i     (port_e_output_latch),
      .e_dir_i       (port_e_direction),
      .lcd_mux_i     (lcd_control_reg[LCD_MUX_LSB+:2]),
      .lcd_segment_thirty_one_en_i    (lcd_segment_enable_24_31[LCD_SEGMENT_THIRTY_ONE_BIT]),
      .ccp_alt_sel_i (compare_pin_select_cfg_i),
      .ccp_out_en_i  (capture_compare_unit_two_out_en_i),
      .ccp_out_i     (capture_compare_unit_two_out_i),
      .d_out_o       (d_out),
      .d_oe_o        (d_oe),
      .d_lcd_o       (d_lcd),
      .e_out_o       (e_out),
      .e_oe_o        (e_oe),
      .e_lcd_o       (e_lcd)
   );

   // Registered pad drive; one cycle after the control write
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         port_d_pad_o     <= '0;
         port_d_pad_oe_o  <= '0;
         port_d_lcd_seg_o <= '0;
         port_e_pad_o     <= '0;
         port_e_pad_oe_o  <= '0;
         port_e_lcd_o     <= '0;
      end else begin
         port_d_pad_o     <= d_out;
         port_d_pad_oe_o  <= d_oe;
         port_d_lcd_seg_o <= d_lcd;
         port_e_pad_o     <= e_out;
         port_e_pad_oe_o  <= e_oe;
         port_e_lcd_o     <= e_lcd;
      end
   end

   // Capture input seen only when pin 7 is routed and digital
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         capture_compare_unit_two_capture_o <= 1'b0;
      end else begin
         capture_compare_unit_two_capture_o <= ~compare_pin_select_cfg_i & ~e_lcd[7] & e_sync[7];
      end
   end

   // ************************************************************
   // Read path
   // ************************************************************
   always_comb begin
      next_rdata = 8'h00;
      unique case (wb_adr_i)
         OFS_PORT_D_PIN_DATA:  next_rdata = d_sync & ~d_lcd;
         OFS_PORT_D_LATCH:     next_rdata = port_d_output_latch;
         OFS_PORT_D_DIRECTION: next_rdata = port_d_direction;
         OFS_LCD_SEG_EN_0_7:   next_rdata = lcd_segment_enable_0_7;
         OFS_PORT_E_PIN_DATA:  next_rdata = e_sync & ~e_lcd & PORT_E_IMPL_MASK;
         OFS_PORT_E_LATCH:     next_rdata = port_e_output_latch;
         OFS_PORT_E_DIRECTION: next_rdata = port_e_direction;
         OFS_LCD_CONTROL:      next_rdata = lcd_control_reg;
         OFS_LCD_SEG_EN_24_31: next_rdata = lcd_segment_enable_24_31;
         default:              next_rdata = 8'h00;
      endcase
   end

   // One wait state: ack the cycle after the request is seen
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
      end else begin
         wb_ack_o <= req;
         wb_dat_o <= req ? {24'h000000, next_rdata} : 32'h00000000;
      end
   end

endmodule : lgp_top
`default_nettype wire

// ==== test/lgp_pin_model.sv ====
// Purpose: Pads and far-side drivers for one port
// Assumes: Pins have no pull, so a floating pin is undefined
// Notes:   A floating pin shows a toggling pattern, never a held value
`timescale 1ns/10ps
`default_nettype none
module lgp_pin_model (
   // Clock
   input  wire logic       clk_i,
   // Device side
   input  wire logic [7:0] drv_i,
   input  wire logic [7:0] drv_oe_i,
   // Outside world
   input  wire logic [7:0] ext_en_i,
   input  wire logic [7:0] ext_val_i,
   // Resolved pad level
   output logic      [7:0] level_o
);
   logic [7:0] float_q = 8'h55;
   always_ff @(posedge clk_i) begin
      float_q <= ~float_q;
   end
   // Device driver wins; then the outside world; else the line floats
   assign level_o = (drv_oe_i & drv_i) | (~drv_oe_i & ext_en_i & ext_val_i)
                  | (~drv_oe_i & ~ext_en_i & float_q);
endmodule : lgp_pin_model
`default_nettype wire

// ==== test/lgp_top_chk.sv ====
// Purpose: Port-level assertions for lgp_top
// Assumes: One clock, synchronous active-low reset
// Notes:   Bound to every lgp_top instance
`timescale 1ns/10ps
`default_nettype none
module lgp_top_chk (
   // Clock and reset
   input wire logic        clk_i,
   input wire logic        rst_n_i,
   // Wishbone
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   // Pads and compare unit
   input wire logic [7:0]  port_d_pad_oe_o,
   input wire logic [7:0]  port_d_lcd_seg_o,
   input wire logic [7:0]  port_e_pad_o,
   input wire logic [7:0]  port_e_pad_oe_o,
   input wire logic [7:0]  port_e_lcd_o,
   input wire logic        compare_pin_select_cfg_i,
   input wire logic        capture_compare_unit_two_capture_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
   sequence s_ans; wb_ack_o ##1 !wb_ack_o; endsequence
   AST_ACK_NEXT: assert property (s_req |=> s_ans)
      else $error("ack not a one-cycle answer");
   AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data outside ack");
   AST_RST_INPUT: assert property (disable iff (1'b0) !rst_n_i |=>
      port_d_pad_oe_o == 8'h00 && port_e_pad_oe_o == 8'h00) else $error("driving after reset");
   AST_D_LCD: assert property ((port_d_pad_oe_o & port_d_lcd_seg_o) == 8'h00)
      else $error("segment pin still driven");
   AST_E_LOW: assert property ((port_e_pad_oe_o[3:0] | port_e_pad_o[3:0]) == 4'h0)
      else $error("low nibble driven");
   AST_E_BIAS: assert property ($past(rst_n_i) |-> port_e_lcd_o[3:0] == 4'hf)
      else $error("bias pins released");
   AST_E_MUX: assert property ($past(rst_n_i) |->
      port_e_lcd_o[6:4] inside {3'b000, 3'b001, 3'b011, 3'b111}) else $error("bad commons");
   AST_E_OWN: assert property ((port_e_pad_oe_o & port_e_lcd_o) == 8'h00)
      else $error("common pin still driven");
   AST_CAP_OFF: assert property (compare_pin_select_cfg_i [*4] |-> !capture_compare_unit_two_capture_o)
      else $error("capture while not routed");
endmodule : lgp_top_chk
bind lgp_top lgp_top_chk i_lgp_top_chk (.clk_i, .rst_n_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o,
   .wb_ack_o, .port_d_pad_oe_o, .port_d_lcd_seg_o, .port_e_pad_o, .port_e_pad_oe_o,
   .port_e_lcd_o, .compare_pin_select_cfg_i, .capture_compare_unit_two_capture_o);
`default_nettype wire

// ==== test/tb_lgp_top.sv ====
// Purpose: Random and corner tests of ports D and E
// Assumes: Wishbone answers one cycle after the request is taken
// Notes:   Port E low pins float in the pin model
`timescale 1ns/10ps
`default_nettype none
module tb_lgp_top;
   import lgp_pkg::*;
   logic        clk_i = 1'b0, rst_n_i = 1'b0;
   logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
   logic [7:0]  wb_adr_i = 8'h00;
   logic [3:0]  wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
   logic [7:0]  d_in, d_out, d_oe, d_seg, e_in, e_out, e_oe, e_lcd;
   logic [7:0]  d_ext = 8'h00, e_ext = 8'h00, r, lat, dir, seg, lcd;
   logic        cfg = 1'b1, ccp_en = 1'b0, ccp_out = 1'b0, cap;
   integer      seed = 32'h6fc43b32;
   int          errors = 0, checked = 0;
   always #20 clk_i = ~clk_i;
   lgp_top i_lgp_top (.clk_i, .rst_n_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
      .wb_dat_i, .wb_dat_o, .wb_ack_o, .port_d_pad_i(d_in), .port_d_pad_o(d_out),
      .port_d_pad_oe_o(d_oe), .port_d_lcd_seg_o(d_seg), .port_e_pad_i(e_in),
      .port_e_pad_o(e_out), .port_e_pad_oe_o(e_oe), .port_e_lcd_o(e_lcd),
      .compare_pin_select_cfg_i(cfg), .capture_compare_unit_two_out_en_i(ccp_en), .capture_compare_unit_two_out_i(ccp_out),
      .capture_compare_unit_two_capture_o(cap));
   lgp_pin_model i_lgp_pin_model_d (.clk_i, .drv_i(d_out), .drv_oe_i(d_oe),
      .ext_en_i(8'hff), .ext_val_i(d_ext), .level_o(d_in));
   lgp_pin_model i_lgp_pin_model_e (.clk_i, .drv_i(e_out), .drv_oe_i(e_oe),
      .ext_en_i(8'hf0), .ext_val_i(e_ext), .level_o(e_in));
   function automatic logic [7:0] e_lcd_exp(input logic [1:0] m, input logic s);
      return {s, m == 2'd3, m >= 2'd2, m >= 2'd1, 4'hf};
   endfunction : e_lcd_exp
   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] v);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_sel_i <= 4'hf;
      wb_dat_i <= {24'h0, v};
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      r = wb_dat_o[7:0];
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask : wb
   task automatic compare(input logic [7:0] exp, input logic [7:0] got);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t: expected %h got %h", $time, exp, got);
      end
   endtask : compare
   task automatic finish_test;
      $display("Comparisons %0d, mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : finish_test
   // Bound well above the few hundred cycles the tests need
   initial begin
      repeat (5000) @(posedge clk_i);
      errors++;
      finish_test();
   end
   initial begin
      repeat (8) @(posedge clk_i);
      rst_n_i <= 1'b1;
      wb(1'b0, OFS_PORT_D_DIRECTION, 8'h00);
      compare(8'hff, r);
      wb(1'b0, OFS_PORT_E_DIRECTION, 8'h00);
      compare(8'hf0, r);
      compare(8'h00, d_oe | e_oe);
      for (int i = 0; i < 6; i++) begin
         lat = 8'($random(seed));
         dir = 8'($random(seed));
         seg = (i == 0) ? 8'h00 : 8'($random(seed));
         d_ext <= 8'($random(seed));
         wb(1'b1, i[0] ? OFS_PORT_D_PIN_DATA : OFS_PORT_D_LATCH, lat);
         wb(1'b1, OFS_PORT_D_DIRECTION, dir);
         wb(1'b1, OFS_LCD_SEG_EN_0_7, seg);
         repeat (4) @(posedge clk_i);
         compare(~dir & ~seg, d_oe);
         compare(lat & ~dir & ~seg, d_out & d_oe);
         compare(seg, d_seg);
         wb(1'b0, OFS_PORT_D_LATCH, 8'h00);
         compare(lat, r);
         wb(1'b0, OFS_PORT_D_DIRECTION, 8'h00);
         compare(dir, r);
         wb(1'b0, OFS_PORT_D_PIN_DATA, 8'h00);
         compare(((~dir & lat) | (dir & d_ext)) & ~seg, r);
      end
      for (int m = 0; m < 4; m++) begin
         lat = 8'($random(seed));
         dir = 8'($random(seed));
         lcd = e_lcd_exp(2'(m), m[0] ^ m[1]);
         cfg <= m[0];
         e_ext <= 8'($random(seed));
         wb(1'b1, OFS_PORT_E_LATCH, lat);
         wb(1'b1, OFS_PORT_E_DIRECTION, dir);
         wb(1'b1, OFS_LCD_CONTROL, 8'(m));
         wb(1'b1, OFS_LCD_SEG_EN_24_31, {lcd[7], 7'h00});
         repeat (4) @(posedge clk_i);
         compare(lcd, e_lcd);
         compare(~dir & ~lcd & 8'hf0, e_oe);
         compare(lat & ~dir & ~lcd & 8'hf0, e_out & e_oe);
         wb(1'b0, OFS_PORT_E_DIRECTION, 8'h00);
         compare(dir & 8'hf0, r);
         wb(1'b0, OFS_PORT_E_LATCH, 8'h00);
         compare(lat & 8'hf0, r);
         wb(1'b0, OFS_PORT_E_PIN_DATA, 8'h00);
         compare(((~dir & lat) | (dir & e_ext)) & ~lcd & 8'hf0, r);
      end
      cfg <= 1'b0;
      ccp_en <= 1'b1;
      ccp_out <= 1'b1;
      wb(1'b1, OFS_LCD_SEG_EN_24_31, 8'h00);
      wb(1'b1, OFS_PORT_E_LATCH, 8'h00);
      wb(1'b1, OFS_PORT_E_DIRECTION, 8'h70);
      repeat (4) @(posedge clk_i);
      compare(8'h01, {7'h00, e_out[7]});
      cfg <= 1'b1;
      repeat (4) @(posedge clk_i);
      compare(8'h00, {7'h00, e_out[7]});
      cfg <= 1'b0;
      ccp_en <= 1'b0;
      e_ext <= 8'h80;
      wb(1'b1, OFS_PORT_E_DIRECTION, 8'hf0);
      repeat (4) @(posedge clk_i);
      compare(8'h01, {7'h00, cap});
      wb(1'b1, 8'h40, 8'h5a);
      wb(1'b0, 8'h40, 8'h00);
      compare(8'h00, r);
      finish_test();
   end
endmodule : tb_lgp_top
`default_nettype wire
